// ===== logic/ldcl_pkg.sv
// Constants, field layout and state types of the LED driver control latch.
package ldcl_pkg;

    // ------------------------------------------------------------
    // Widths and positions
    // ------------------------------------------------------------
    localparam int SHIFT_W = 769;
    localparam int SHIFT_TOP = 768;
    localparam int CTL_W = 371;
    localparam int CORR_BITS = 336;
    localparam int CHANNELS = 16;
    localparam int CORR_W = 7;
    localparam int CH_STRIDE = 21;
    localparam int RED_OFS = 0;
    localparam int GRN_OFS = 7;
    localparam int BLU_OFS = 14;
    localparam int RANGE_LSB = 336;
    localparam int RANGE_W = 3;
    localparam int RANGE_ALL_W = 9;
    localparam int BRT_RED_LSB = 345;
    localparam int BRT_GRN_LSB = 352;
    localparam int BRT_BLU_LSB = 359;
    localparam int BRT_W = 7;
    localparam int FUNC_LSB = 366;
    localparam int FUNC_W = 5;
    localparam int AUTO_REFRESH_BIT = 368;
    localparam int REFRESH_CLOCKS = 65536;
    localparam int CNT_W = 17;

    typedef logic [CNT_W-1:0] ldcl_cnt_t;
    typedef logic [CHANNELS-1:0][CORR_W-1:0] ldcl_corr_t;

    typedef enum logic [0:0] {
        LDCL_IDLE = 1'b0,
        LDCL_COUNT = 1'b1
    } ldcl_cnt_state_t;

    // ------------------------------------------------------------
    // State of the system-clock side
    // ------------------------------------------------------------
    typedef struct packed {
        logic strobeSync1;
        logic strobeSync2;
        logic strobePrev;
        logic [CTL_W-1:0] ctl;
        logic [RANGE_ALL_W-1:0] rangePend;
        logic pendValid;
        logic [RANGE_ALL_W-1:0] rangeEff;
        ldcl_corr_t corrRed;
        ldcl_corr_t corrGreen;
        ldcl_corr_t corrBlue;
        logic [BRT_W-1:0] brtRed;
        logic [BRT_W-1:0] brtGreen;
        logic [BRT_W-1:0] brtBlue;
        logic [FUNC_W-1:0] func;
        logic reqTog;
        logic ackSync1;
        logic ackSync2;
        logic ackPrev;
    } ldcl_sys_t;

    // ------------------------------------------------------------
    // State of the counting-clock side
    // ------------------------------------------------------------
    typedef struct packed {
        logic rstSync1;
        logic rstSync2;
        logic enSync1;
        logic enSync2;
        logic reqSync1;
        logic reqSync2;
        logic reqPrev;
        ldcl_cnt_state_t state;
        ldcl_cnt_t cnt;
        logic ackTog;
    } ldcl_link_t;

endpackage : ldcl_pkg

// ===== logic/ldcl_ctrl_latch.sv
// Control latch, range double-write filter and working correction latch.
`timescale 1ns/1ps

module ldcl_ctrl_latch #(
    parameter int REFRESH_CLOCKS = ldcl_pkg::REFRESH_CLOCKS
) (
    // System clock domain
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // Counting clock domain
    input wire logic pwm_count_clock,
    // Serial side
    input wire logic latch_strobe,
    input wire logic [ldcl_pkg::SHIFT_W-1:0] shiftWord,
    // Working correction per colour group
    output logic [ldcl_pkg::CHANNELS-1:0][ldcl_pkg::CORR_W-1:0] red_correction_field,
    output logic [ldcl_pkg::CHANNELS-1:0][ldcl_pkg::CORR_W-1:0] green_correction_field,
    output logic [ldcl_pkg::CHANNELS-1:0][ldcl_pkg::CORR_W-1:0] blue_correction_field,
    // Group settings
    output logic [ldcl_pkg::RANGE_W-1:0] red_range_field,
    output logic [ldcl_pkg::RANGE_W-1:0] green_range_field,
    output logic [ldcl_pkg::RANGE_W-1:0] blue_range_field,
    output logic [ldcl_pkg::BRT_W-1:0] red_brightness_field,
    output logic [ldcl_pkg::BRT_W-1:0] green_brightness_field,
    output logic [ldcl_pkg::BRT_W-1:0] blue_brightness_field,
    output logic [ldcl_pkg::FUNC_W-1:0] function_settings
);

    localparam ldcl_pkg::ldcl_cnt_t REFRESH_LOAD = ldcl_pkg::ldcl_cnt_t'(REFRESH_CLOCKS);
    localparam ldcl_pkg::ldcl_cnt_t CNT_LAST = ldcl_pkg::ldcl_cnt_t'(1);
    localparam int AR_IDX = ldcl_pkg::AUTO_REFRESH_BIT;
    localparam int RL = ldcl_pkg::RANGE_LSB;
    localparam int RW = ldcl_pkg::RANGE_ALL_W;
    localparam int LAST_BASE = (ldcl_pkg::CHANNELS-1)*ldcl_pkg::CH_STRIDE;

    ldcl_pkg::ldcl_sys_t sys_r;
    ldcl_pkg::ldcl_sys_t sys_nxt;
    ldcl_pkg::ldcl_link_t link_r;
    ldcl_pkg::ldcl_link_t link_nxt;

    logic strobeEdge;
    logic ctlWrite;
    logic gsWrite;
    logic ackEdge;
    logic autoRefresh;
    logic copyNow;
    logic reqEdge;
    logic [RW-1:0] rangeIn;

    // ------------------------------------------------------------
    // Strobe decode
    // ------------------------------------------------------------
    assign strobeEdge = clkEn && sys_r.strobeSync2 && !sys_r.strobePrev;
    assign ctlWrite = strobeEdge && shiftWord[ldcl_pkg::SHIFT_TOP];
    assign gsWrite = strobeEdge && !shiftWord[ldcl_pkg::SHIFT_TOP];
    assign ackEdge = clkEn && (sys_r.ackSync2 ^ sys_r.ackPrev);
    assign autoRefresh = sys_r.ctl[AR_IDX];
    assign copyNow = (gsWrite && !autoRefresh) || ackEdge;
    assign rangeIn = shiftWord[RL +: RW];

    // ------------------------------------------------------------
    // System clock side
    // ------------------------------------------------------------
    always_comb begin
        sys_nxt = sys_r;
        if (clkEn) begin
            sys_nxt.strobeSync1 = latch_strobe;
            sys_nxt.strobeSync2 = sys_r.strobeSync1;
            sys_nxt.strobePrev = sys_r.strobeSync2;
            sys_nxt.ackSync1 = link_r.ackTog;
            sys_nxt.ackSync2 = sys_r.ackSync1;
            sys_nxt.ackPrev = sys_r.ackSync2;
            if (ctlWrite) begin
                sys_nxt.ctl = shiftWord[ldcl_pkg::CTL_W-1:0];
                sys_nxt.brtRed = shiftWord[ldcl_pkg::BRT_RED_LSB +: ldcl_pkg::BRT_W];
                sys_nxt.brtGreen = shiftWord[ldcl_pkg::BRT_GRN_LSB +: ldcl_pkg::BRT_W];
                sys_nxt.brtBlue = shiftWord[ldcl_pkg::BRT_BLU_LSB +: ldcl_pkg::BRT_W];
                sys_nxt.func = shiftWord[ldcl_pkg::FUNC_LSB +: ldcl_pkg::FUNC_W];
                // Guards against a single corrupted word changing the current range
                if (sys_r.pendValid && (rangeIn == sys_r.rangePend)) begin
                    sys_nxt.rangeEff = rangeIn;
                end
                sys_nxt.rangePend = rangeIn;
                sys_nxt.pendValid = 1'b1;
            end
            if (gsWrite && autoRefresh) begin
                sys_nxt.reqTog = !sys_r.reqTog;
            end
            // Control writes never reach the working latch directly
            if (copyNow) begin
                for (int ch = 0; ch < ldcl_pkg::CHANNELS; ch++) begin
                    sys_nxt.corrRed[ch] =
                        sys_r.ctl[ch*ldcl_pkg::CH_STRIDE+ldcl_pkg::RED_OFS +: ldcl_pkg::CORR_W];
                    sys_nxt.corrGreen[ch] =
                        sys_r.ctl[ch*ldcl_pkg::CH_STRIDE+ldcl_pkg::GRN_OFS +: ldcl_pkg::CORR_W];
                    sys_nxt.corrBlue[ch] =
                        sys_r.ctl[ch*ldcl_pkg::CH_STRIDE+ldcl_pkg::BLU_OFS +: ldcl_pkg::CORR_W];
                end
            end
        end
        // Undefined power-up data is modelled as zero; range zero is required
        if (rst) begin
            sys_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        sys_r <= sys_nxt;
    end

    // ------------------------------------------------------------
    // Counting clock side
    // ------------------------------------------------------------
    assign reqEdge = link_r.reqSync2 ^ link_r.reqPrev;

    always_comb begin
        link_nxt = link_r;
        link_nxt.rstSync1 = rst;
        link_nxt.rstSync2 = link_r.rstSync1;
        link_nxt.enSync1 = clkEn;
        link_nxt.enSync2 = link_r.enSync1;
        link_nxt.reqSync1 = sys_r.reqTog;
        link_nxt.reqSync2 = link_r.reqSync1;
        // Sync flops keep running while frozen so no request is lost
        if (link_r.enSync2) begin
            link_nxt.reqPrev = link_r.reqSync2;
            case (link_r.state)
                ldcl_pkg::LDCL_IDLE: begin
                    if (reqEdge) begin
                        link_nxt.cnt = REFRESH_LOAD;
                        link_nxt.state = ldcl_pkg::LDCL_COUNT;
                    end
                end
                ldcl_pkg::LDCL_COUNT: begin
                    // A newer grayscale write restarts the full cycle
                    if (reqEdge) begin
                        link_nxt.cnt = REFRESH_LOAD;
                    end else if (link_r.cnt == CNT_LAST) begin
                        link_nxt.ackTog = !link_r.ackTog;
                        link_nxt.state = ldcl_pkg::LDCL_IDLE;
                    end else begin
                        link_nxt.cnt = link_r.cnt - CNT_LAST;
                    end
                end
                default: begin
                    link_nxt.state = ldcl_pkg::LDCL_IDLE;
                end
            endcase
        end
        if (link_r.rstSync2) begin
            link_nxt.reqPrev = link_r.reqSync2;
            link_nxt.state = ldcl_pkg::LDCL_IDLE;
            link_nxt.cnt = '0;
            // Unknown toggle would hide every later refresh edge
            link_nxt.ackTog = 1'h0;
        end
    end

    always_ff @(posedge pwm_count_clock) begin
        link_r <= link_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign red_correction_field = sys_r.corrRed;
    assign green_correction_field = sys_r.corrGreen;
    assign blue_correction_field = sys_r.corrBlue;
    assign red_range_field = sys_r.rangeEff[0 +: ldcl_pkg::RANGE_W];
    assign green_range_field = sys_r.rangeEff[ldcl_pkg::RANGE_W +: ldcl_pkg::RANGE_W];
    assign blue_range_field = sys_r.rangeEff[2*ldcl_pkg::RANGE_W +: ldcl_pkg::RANGE_W];
    assign red_brightness_field = sys_r.brtRed;
    assign green_brightness_field = sys_r.brtGreen;
    assign blue_brightness_field = sys_r.brtBlue;
    assign function_settings = sys_r.func;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_ctrl_load: assert property (
        @(posedge sys_clk) disable iff (rst)
        ctlWrite |=> sys_r.ctl == $past(shiftWord[ldcl_pkg::CTL_W-1:0])
    ) else $error("control word not loaded on control write");

    chk_gs_keeps_ctl: assert property (
        @(posedge sys_clk) disable iff (rst)
        gsWrite |=> $stable(sys_r.ctl) && $stable(sys_r.brtRed)
    ) else $error("grayscale write changed control latch");

    chk_direct_copy: assert property (
        @(posedge sys_clk) disable iff (rst)
        gsWrite && !autoRefresh |=>
            sys_r.corrRed[0] == $past(sys_r.ctl[ldcl_pkg::RED_OFS +: ldcl_pkg::CORR_W])
            && sys_r.corrBlue[ldcl_pkg::CHANNELS-1] ==
            $past(sys_r.ctl[ldcl_pkg::CORR_BITS-1 -: ldcl_pkg::CORR_W])
    ) else $error("correction not copied on grayscale write");

    chk_ctl_keeps_corr: assert property (
        @(posedge sys_clk) disable iff (rst)
        ctlWrite && !ackEdge |=> $stable(sys_r.corrGreen) && $stable(sys_r.corrRed)
    ) else $error("control write touched working correction");

    chk_auto_holds: assert property (
        @(posedge sys_clk) disable iff (rst)
        gsWrite && autoRefresh && !ackEdge |=>
            $stable(sys_r.corrBlue) && (sys_r.reqTog != $past(sys_r.reqTog))
    ) else $error("auto refresh copied early or raised no request");

    chk_auto_copy: assert property (
        @(posedge sys_clk) disable iff (rst)
        ackEdge |=> sys_r.corrGreen[1] ==
            $past(sys_r.ctl[ldcl_pkg::CH_STRIDE+ldcl_pkg::GRN_OFS +: ldcl_pkg::CORR_W])
    ) else $error("correction not copied when refresh count ends");

    chk_range_reset: assert property (
        @(posedge sys_clk)
        rst |=> sys_r.rangeEff == '0 && !sys_r.pendValid
    ) else $error("range fields not zero after reset");

    chk_range_twice: assert property (
        @(posedge sys_clk) disable iff (rst)
        sys_r.rangeEff != $past(sys_r.rangeEff) |->
            $past(ctlWrite) && $past(sys_r.rangePend) == sys_r.rangeEff
    ) else $error("range changed without a repeated write");

    chk_bright_map: assert property (
        @(posedge sys_clk) disable iff (rst)
        ctlWrite |=> sys_r.brtBlue ==
            $past(shiftWord[ldcl_pkg::BRT_BLU_LSB +: ldcl_pkg::BRT_W])
            && sys_r.func == $past(shiftWord[ldcl_pkg::FUNC_LSB +: ldcl_pkg::FUNC_W])
    ) else $error("brightness field taken from wrong bits");

    chk_count_load: assert property (
        @(posedge pwm_count_clock) disable iff (link_r.rstSync2)
        link_r.enSync2 && reqEdge |=>
            link_r.cnt == REFRESH_LOAD && link_r.state == ldcl_pkg::LDCL_COUNT
    ) else $error("refresh counter not loaded");

    chk_count_done: assert property (
        @(posedge pwm_count_clock) disable iff (link_r.rstSync2)
        link_r.ackTog != $past(link_r.ackTog) |->
            $past(link_r.cnt) == CNT_LAST && link_r.state == ldcl_pkg::LDCL_IDLE
    ) else $error("refresh ended before full count");

    chk_reset_clear: assert property (
        @(posedge sys_clk)
        rst |=> sys_r.ctl == '0 && sys_r.corrRed == '0
            && !sys_r.reqTog && !sys_r.strobePrev
    ) else $error("system state not cleared by reset");

    chk_freeze_sys: assert property (
        @(posedge sys_clk) disable iff (rst)
        !clkEn |=>
            $stable(sys_r)
    ) else $error("system state moved while clock enable low");

    chk_red_map: assert property (
        @(posedge sys_clk) disable iff (rst)
        copyNow |=> sys_r.corrRed[ldcl_pkg::CHANNELS-1] ==
            $past(sys_r.ctl[LAST_BASE+ldcl_pkg::RED_OFS +: ldcl_pkg::CORR_W])
    ) else $error("red correction taken from wrong bits");

    chk_green_map: assert property (
        @(posedge sys_clk) disable iff (rst)
        copyNow |=> sys_r.corrGreen[ldcl_pkg::CHANNELS-1] ==
            $past(sys_r.ctl[LAST_BASE+ldcl_pkg::GRN_OFS +: ldcl_pkg::CORR_W])
    ) else $error("green correction taken from wrong bits");

    chk_blue_map: assert property (
        @(posedge sys_clk) disable iff (rst)
        copyNow |=> sys_r.corrBlue[0] ==
            $past(sys_r.ctl[ldcl_pkg::BLU_OFS +: ldcl_pkg::CORR_W])
    ) else $error("blue correction taken from wrong bits");

    chk_corr_idle: assert property (
        @(posedge sys_clk) disable iff (rst)
        !copyNow |=>
            $stable(sys_r.corrRed) && $stable(sys_r.corrGreen) && $stable(sys_r.corrBlue)
    ) else $error("working correction changed without a copy");

    chk_range_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        !ctlWrite |=>
            $stable(sys_r.rangeEff) && $stable(sys_r.func)
    ) else $error("range or function changed without control write");

    chk_first_range: assert property (
        @(posedge sys_clk) disable iff (rst)
        ctlWrite && !sys_r.pendValid |=>
            $stable(sys_r.rangeEff) && sys_r.pendValid
    ) else $error("first control write after reset changed range");

    chk_count_step: assert property (
        @(posedge pwm_count_clock) disable iff (link_r.rstSync2)
        link_r.enSync2 && link_r.state == ldcl_pkg::LDCL_COUNT && !reqEdge
            && link_r.cnt != CNT_LAST |=> link_r.cnt == $past(link_r.cnt) - CNT_LAST
    ) else $error("refresh counter skipped a step");

    chk_freeze_link: assert property (
        @(posedge pwm_count_clock) disable iff (link_r.rstSync2)
        !link_r.enSync2 |=>
            $stable(link_r.cnt) && $stable(link_r.ackTog) && $stable(link_r.state)
    ) else $error("refresh counter moved while frozen");

endmodule : ldcl_ctrl_latch

// ===== test/ldcl_host_model.sv
// Host model that loads the shift word and pulses the latch strobe.
`timescale 1ns/1ps

module ldcl_host_model (
    // Clock
    input wire logic sys_clk,
    // Serial side toward the device
    output logic latch_strobe,
    output logic [ldcl_pkg::SHIFT_W-1:0] shiftWord
);
    initial begin
        latch_strobe = 1'h0;
        shiftWord = '0;
    end

    // ------------------------------------------------------------
    // One write
    // ------------------------------------------------------------
    // Word is scrambled after the strobe so a late sample shows up
    task automatic send(input logic [ldcl_pkg::SHIFT_W-1:0] w);
        @(negedge sys_clk);
        shiftWord = w;
        latch_strobe = 1'h1;
        repeat (4) @(negedge sys_clk);
        latch_strobe = 1'h0;
        repeat (4) @(negedge sys_clk);
        shiftWord = ~w;
    endtask : send
endmodule : ldcl_host_model

// ===== test/led_driver_control_latch_bench.sv
// Self-checking bench of the LED driver control latch.
`timescale 1ns/1ps

module led_driver_control_latch_bench;
    typedef struct packed {
        logic [335:0] corr;
        logic [8:0] range;
        logic [20:0] brt;
        logic [4:0] func;
    } ldcl_exp_t;

    logic sys_clk = 1'h0;
    logic pwm_count_clock = 1'h0;
    logic rst = 1'h1;
    logic clkEn = 1'h1;
    logic latch_strobe;
    logic [ldcl_pkg::SHIFT_W-1:0] shiftWord;
    ldcl_pkg::ldcl_corr_t redCorr;
    ldcl_pkg::ldcl_corr_t greenCorr;
    ldcl_pkg::ldcl_corr_t blueCorr;
    logic [2:0] redRange;
    logic [2:0] greenRange;
    logic [2:0] blueRange;
    logic [6:0] redBrt;
    logic [6:0] greenBrt;
    logic [6:0] blueBrt;
    logic [4:0] funcBits;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    logic sampleNow = 1'h0;
    ldcl_exp_t notes[$];
    ldcl_exp_t seen;
    ldcl_exp_t want;
    logic [370:0] ctlRef = '0;
    logic [8:0] pendRef = '0;
    logic pendOk = 1'h0;
    logic [8:0] rangeRef = '0;
    logic [335:0] corrRef = '0;
    logic [335:0] corrLater = '0;
    logic [31:0] seed = 32'h0000000A;

    initial forever #5 sys_clk = ~sys_clk;
    // Offset start delays the counting clock by 3 ns; its rising edges still meet sys_clk every 60 ns
    initial begin
        #3;
        forever #6 pwm_count_clock = ~pwm_count_clock;
    end

    ldcl_ctrl_latch #(.REFRESH_CLOCKS(8)) u_ldcl_ctrl_latch (
        .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .pwm_count_clock(pwm_count_clock),
        .latch_strobe(latch_strobe), .shiftWord(shiftWord),
        .red_correction_field(redCorr), .green_correction_field(greenCorr),
        .blue_correction_field(blueCorr), .red_range_field(redRange),
        .green_range_field(greenRange), .blue_range_field(blueRange),
        .red_brightness_field(redBrt), .green_brightness_field(greenBrt),
        .blue_brightness_field(blueBrt), .function_settings(funcBits)
    );

    ldcl_host_model u_ldcl_host_model (
        .sys_clk(sys_clk), .latch_strobe(latch_strobe), .shiftWord(shiftWord)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [335:0] pack_corr(input ldcl_pkg::ldcl_corr_t r,
            input ldcl_pkg::ldcl_corr_t g, input ldcl_pkg::ldcl_corr_t b);
        logic [335:0] v;
        for (int n = 0; n < 16; n++) begin
            v[21*n +: 21] = {b[n], g[n], r[n]};
        end
        return v;
    endfunction : pack_corr

    task automatic rand_word(input logic top, input logic refresh, output logic [768:0] w);
        logic [799:0] r;
        for (int i = 0; i < 25; i++) begin
            seed = lfsr(seed);
            r[32*i +: 32] = seed;
        end
        w = r[768:0];
        w[ldcl_pkg::SHIFT_TOP] = top;
        w[ldcl_pkg::AUTO_REFRESH_BIT] = refresh;
    endtask : rand_word

    // Reference update mirrors one write, then the host sends it
    task automatic write(input logic [768:0] w);
        if (w[768]) begin
            if (pendOk && pendRef === w[344:336]) begin
                rangeRef = w[344:336];
            end
            pendRef = w[344:336];
            pendOk = 1'h1;
            ctlRef = w[370:0];
        end else if (ctlRef[368]) begin
            corrLater = ctlRef[335:0];
        end else begin
            corrRef = ctlRef[335:0];
        end
        u_ldcl_host_model.send(w);
        repeat (2) @(negedge sys_clk);
    endtask : write

    task automatic expect_now();
        ldcl_exp_t e;
        e = {corrRef, rangeRef, ctlRef[365:345], ctlRef[370:366]};
        notes.push_back(e);
        @(negedge sys_clk);
        sampleNow = 1'h1;
        @(negedge sys_clk);
        sampleNow = 1'h0;
    endtask : expect_now

    task automatic conclude();
        $display("Checked %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (sampleNow) begin
            want = notes.pop_front();
            seen = {pack_corr(redCorr, greenCorr, blueCorr), {blueRange, greenRange, redRange},
                    {blueBrt, greenBrt, redBrt}, funcBits};
            checked++;
            if (seen !== want) begin
                failures++;
                $display("Error at %0t: expected %h, got %h", $time, want, seen);
            end
        end
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [768:0] a;
        logic [768:0] w;
        repeat (6) @(negedge sys_clk);
        rst = 1'h0;
        expect_now();
        for (int k = 0; k < 2; k++) begin
            rand_word(1'h1, 1'h0, a);
            write(a);
            expect_now();
            write(a);
            expect_now();
            rand_word(1'h0, 1'h0, w);
            write(w);
            expect_now();
            rand_word(1'h1, 1'h1, a);
            write(a);
            expect_now();
            rand_word(1'h0, 1'h0, w);
            write(w);
            expect_now();
            repeat (40) @(negedge sys_clk);
            corrRef = corrLater;
            expect_now();
        end
        // Frozen block must ignore a whole strobe pulse
        rand_word(1'h1, 1'h0, a);
        clkEn = 1'h0;
        u_ldcl_host_model.send(a);
        clkEn = 1'h1;
        repeat (2) @(negedge sys_clk);
        expect_now();
        rst = 1'h1;
        repeat (6) @(negedge sys_clk);
        rst = 1'h0;
        ctlRef = '0;
        rangeRef = '0;
        pendOk = 1'h0;
        corrRef = '0;
        expect_now();
        write(a);
        expect_now();
        conclude();
    end
endmodule : led_driver_control_latch_bench
